// [rtl/quad_line_pkg.sv]
package quad_line_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_CHAN = 4;   // serial channels sharing ready pins
   localparam int CHAR_W = 8;     // received character width
   localparam int RX_DEPTH = 8;   // words of buffering per channel

   // ----------------------------------------------------------------
   // levels after reset and while idle
   // ----------------------------------------------------------------
   localparam logic LINE_IDLE = 1'h1;   // mark level of a serial line
   localparam logic READY_OFF_N = 1'h1; // active-low ready, negated
   localparam logic OSC_RESET = 1'h0;   // clock output level in reset

   // ----------------------------------------------------------------
   // per-channel pin and control group
   // ----------------------------------------------------------------
   typedef struct packed {
      logic serial_in;  // external receive pin level
      logic tx_bit;     // bit the transmitter wants on the line
      logic tx_active;  // transmitter is shifting a character
      logic tx_enable;  // transmitter enabled
      logic loopback;   // local loop-back mode selected
      logic tx_space;   // transmit holding reg or buffer has room
   } chan_ctl_t;

   // character handed from the internal receiver
   typedef struct packed {
      logic valid;
      logic [CHAR_W-1:0] data;
   } rx_char_t;
endpackage : quad_line_pkg

// [rtl/char_fifo.sv]
`timescale 1ns/1ps
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // filling side
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   // draining side
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data
);
   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // pointers wrap naturally, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("char_fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];  // storage flops
   logic [AW-1:0] wr_ptr_q;          // next slot to write
   logic [AW-1:0] rd_ptr_q;          // oldest word
   logic [AW:0] count_q;             // words held
   logic [AW:0] count_d;
   logic push;
   logic pop;

   // ----------------------------------------------------------------
   // handshakes
   // ----------------------------------------------------------------
   assign push = i_wr_valid && o_wr_ready;
   assign pop = o_rd_valid && i_rd_ready;
   assign o_rd_data = mem_q[rd_ptr_q];

   // occupancy after this cycle
   always_comb begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   // storage, no reset needed on data
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_wr_data;
      end
   end

   // pointers and count
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
         count_q <= count_d;
      end
   end

   // flags registered so full and empty come from flops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wr_ready <= 1'b1;
         o_rd_valid <= 1'b0;
      end else begin
         o_wr_ready <= (count_d != (AW+1)'(DEPTH));
         o_rd_valid <= (count_d != '0);
      end
   end
endmodule : char_fifo

// [rtl/quad_line_pins.sv]
// Behaviour
// R1 - transmit pin high in reset, idle, disabled
// R2 - remote holds receive pin high when idle
// R3 - loop-back disables pin, loops transmit inward
// R4 - loop-back ignores external receive pin
// R5 - receive-ready low when any channel holds data
// R6 - receive-ready high once all channels empty
// R7 - transmit-ready low when any channel has room
// R8 - transmit-ready high only when all full
// R9 - per-channel ready status exposed separately
// R10 - reference from crystal or external clock
// R11 - buffered oscillator output on companion pin (the code gives it at half the reference rate)
// R12 - reset returns outputs, disables serial lines
// R13 - shared ready is AND of channel readies
`timescale 1ns/1ps
module quad_line_pins #(
   parameter int NCH = quad_line_pkg::NUM_CHAN,
   parameter int CW = quad_line_pkg::CHAR_W,
   parameter int DEPTH = quad_line_pkg::RX_DEPTH
) (
   // reference clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // serial side and transmitter controls
   input wire quad_line_pkg::chan_ctl_t [NCH-1:0] i_chan,
   output logic [NCH-1:0] o_serial_out,
   output logic [NCH-1:0] o_rx_line,
   // characters from the internal receivers
   input wire quad_line_pkg::rx_char_t [NCH-1:0] i_rx_char,
   output logic [NCH-1:0] o_rx_char_ready,
   // host unload port
   input wire logic [NCH-1:0] i_host_pop,
   output logic [NCH-1:0] o_host_valid,
   output logic [NCH-1:0][CW-1:0] o_host_data,
   // readiness, per channel and shared
   output logic [NCH-1:0] o_receive_ready_chan_n,
   output logic [NCH-1:0] o_transmit_ready_chan_n,
   output logic o_receive_ready_all_n,
   output logic o_transmit_ready_all_n,
   // reference divided by two
   output logic o_osc_clock_out
);
   import quad_line_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (NCH < 1 || CW < 1) begin : g_bad_size
      $error("quad_line_pins needs at least one channel and data bit");
   end

   // merge of active-low flags: any low pulls the result low
   function automatic logic and_all_n(input logic [NCH-1:0] v);
      and_all_n = &v;  // see R13
   endfunction : and_all_n

   logic [NCH-1:0] fifo_valid;   // channel buffer holds a character
   logic [NCH-1:0] fifo_pop;     // host unload accepted
   logic [NCH-1:0][CW-1:0] fifo_data;
   logic [NCH-1:0] rx_rdy_n;     // per-channel receive ready, low
   logic [NCH-1:0] tx_rdy_n;     // per-channel transmit ready, low
   logic osc_q;                  // divided reference

   // ----------------------------------------------------------------
   // receive buffering, one fifo per channel
   // ----------------------------------------------------------------
   for (genvar c = 0; c < NCH; c++) begin : g_chan
      char_fifo #(
         .WIDTH(CW),
         .DEPTH(DEPTH)
      ) u_fifo (
         .i_clk(i_clk),
         .i_rst_n(i_rst_n),
         .i_wr_valid(i_rx_char[c].valid),
         .o_wr_ready(o_rx_char_ready[c]),
         .i_wr_data(i_rx_char[c].data),
         .o_rd_valid(fifo_valid[c]),
         .i_rd_ready(i_host_pop[c]),
         .o_rd_data(fifo_data[c])
      );
   end

   assign fifo_pop = fifo_valid & i_host_pop;
   // a channel with a buffered character is ready to unload
   assign rx_rdy_n = ~fifo_valid;  // see R5
   // transmit readiness is only a level from the transmitter side
   always_comb begin
      tx_rdy_n = '1;
      for (int c = 0; c < NCH; c++) begin
         tx_rdy_n[c] = ~i_chan[c].tx_space;  // see R7
      end
   end

   // ----------------------------------------------------------------
   // serial transmit pins
   // ----------------------------------------------------------------
   // mark level unless an enabled, non-looped transmitter is shifting
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_serial_out <= {NCH{LINE_IDLE}};  // see R12
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (i_chan[c].loopback) begin
               o_serial_out[c] <= LINE_IDLE;  // see R3
            end else if (i_chan[c].tx_enable && i_chan[c].tx_active) begin
               o_serial_out[c] <= i_chan[c].tx_bit;
            end else begin
               o_serial_out[c] <= LINE_IDLE;  // see R1
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // receiver line selection
   // ----------------------------------------------------------------
   // the remote side keeps the pin at mark while idle, so the
   // receiver needs no extra gating in normal mode (see R2)
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx_line <= {NCH{LINE_IDLE}};  // see R12
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (i_chan[c].loopback) begin
               // pin ignored, transmit stream fed back
               o_rx_line[c] <= (i_chan[c].tx_enable &&
                                i_chan[c].tx_active) ?
                               i_chan[c].tx_bit : LINE_IDLE;  // see R4
            end else begin
               o_rx_line[c] <= i_chan[c].serial_in;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // host unload register
   // ----------------------------------------------------------------
   // one-cycle valid with the unloaded character
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_host_valid <= '0;
         o_host_data <= '0;
      end else begin
         o_host_valid <= fifo_pop;
         for (int c = 0; c < NCH; c++) begin
            if (fifo_pop[c]) o_host_data[c] <= fifo_data[c];
         end
      end
   end

   // ----------------------------------------------------------------
   // ready pins, per channel and merged
   // ----------------------------------------------------------------
   // registered, so the pins lag the buffer state by one cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_receive_ready_chan_n <= {NCH{READY_OFF_N}};
         o_transmit_ready_chan_n <= {NCH{READY_OFF_N}};
         o_receive_ready_all_n <= READY_OFF_N;
         o_transmit_ready_all_n <= READY_OFF_N;
      end else begin
         o_receive_ready_chan_n <= rx_rdy_n;   // see R9
         o_transmit_ready_chan_n <= tx_rdy_n;  // see R9
         o_receive_ready_all_n <= and_all_n(rx_rdy_n);   // see R6
         o_transmit_ready_all_n <= and_all_n(tx_rdy_n);  // see R8
      end
   end

   // ----------------------------------------------------------------
   // oscillator companion output
   // ----------------------------------------------------------------
   // a flop cannot copy a clock edge for edge, so the buffered
   // reference is given at half rate (see R11)
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         osc_q <= OSC_RESET;
      end else begin
         osc_q <= ~osc_q;  // see R11
      end
   end
   assign o_osc_clock_out = osc_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_loop_a;
      i_chan[0].loopback;
   endsequence
   sequence s_tx_idle_a;
      !i_chan[0].tx_active || !i_chan[0].tx_enable;
   endsequence

   chk_loop_pin_high: assert property (s_loop_a |=> o_serial_out[0]) // see R3
      else $error("transmit pin not high in loop-back");
   chk_idle_pin_high: assert property ( // see R1
      s_tx_idle_a |=> o_serial_out[0])
      else $error("transmit pin not high while idle or disabled");
   chk_loop_rx_path: assert property (
      s_loop_a ##0 (i_chan[0].tx_enable && i_chan[0].tx_active) |=>
      o_rx_line[0] == $past(i_chan[0].tx_bit)) // see R4
      else $error("receiver does not see looped transmit bit");
   chk_rx_any_low: assert property (
      (|fifo_valid) |=> !o_receive_ready_all_n) // see R5
      else $error("shared receive ready not low with data held");
   chk_rx_none_high: assert property (
      !(|fifo_valid) |=> o_receive_ready_all_n) // see R6
      else $error("shared receive ready low with all channels empty");
   chk_tx_any_low: assert property (
      (tx_rdy_n != '1) |=> !o_transmit_ready_all_n) // see R7
      else $error("shared transmit ready not low with room present");
   chk_tx_all_high: assert property (
      (tx_rdy_n == '1) |=> o_transmit_ready_all_n) // see R8
      else $error("shared transmit ready low with every channel full");
   chk_chan_ready: assert property (
      ##1 o_receive_ready_chan_n == ~$past(fifo_valid)) // see R9
      else $error("per-channel receive ready mismatch");
   chk_osc_toggle: assert property (
      o_osc_clock_out |=> !o_osc_clock_out ##1 o_osc_clock_out) // see R11
      else $error("buffered clock output not toggling");
   chk_reset_lines: assert property (
      $rose(i_rst_n) |-> (o_serial_out == '1 && o_rx_line == '1)) // see R12
      else $error("serial lines not at mark after reset");
endmodule : quad_line_pins

// [tb/remote_party.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: remote line driver and character source
// ------------------------------------------------------------
module remote_party #(
   parameter int NCH = 4,
   parameter int CW = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // line requests from the bench
   input wire logic [NCH-1:0] i_line_send,
   input wire logic [NCH-1:0] i_line_bits,
   // characters queued by the bench
   input wire logic i_push,
   input wire logic [1:0] i_push_ch,
   input wire logic [CW-1:0] i_push_data,
   // offer towards the block
   input wire logic [NCH-1:0] i_char_ready,
   output quad_line_pkg::rx_char_t [NCH-1:0] o_char,
   output logic [NCH-1:0] o_serial_in
);
   import quad_line_pkg::*;
   logic [CW-1:0] pend_q [NCH][$]; // words not yet taken

   // line sits at mark unless a bit is being sent
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) o_serial_in <= '1;
      else o_serial_in <= (i_line_send & i_line_bits) | ~i_line_send;
   end

   // offer held until taken, so a refusal just stalls the head
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int c = 0; c < NCH; c++) begin
            pend_q[c].delete();
            o_char[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (o_char[c].valid && i_char_ready[c]) begin
               void'(pend_q[c].pop_front());
            end
            if (i_push && int'(i_push_ch) == c) begin
               pend_q[c].push_back(i_push_data);
            end
            // idle data flips so stale bytes never look fresh
            if (pend_q[c].size() > 0) o_char[c] <= {1'b1, pend_q[c][0]};
            else o_char[c] <= {1'b0, ~o_char[c].data};
         end
      end
   end
endmodule : remote_party

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   import quad_line_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   chan_ctl_t [3:0] ctl = '0; // bench-driven controls
   chan_ctl_t [3:0] chan_in; // controls plus remote line
   rx_char_t [3:0] rx_char;
   logic [3:0] line_send = '0;
   logic [3:0] line_bits = '0;
   logic push = 1'b0;
   logic [1:0] push_ch = 2'h0;
   logic [7:0] push_data = 8'h00;
   logic [3:0] pop = '0;
   logic [3:0] serial_in, serial_out, rx_line, char_ready, host_valid;
   logic [3:0][7:0] host_data;
   logic [3:0] rx_rdy_n, tx_rdy_n;
   logic rx_all_n, tx_all_n, osc;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   // case table: {bit, act, en, loop, ext, exp_out, exp_line}
   logic [6:0] tbl [6] = '{7'h35, 7'h12, 7'h27, 7'h3E, 7'h7B, 7'h2F};

   always #2.5 clk = ~clk;
   always_comb begin
      chan_in = ctl;
      for (int c = 0; c < 4; c++) chan_in[c].serial_in = serial_in[c];
   end

   quad_line_pins DUT (.i_clk(clk), .i_rst_n(rst_n), .i_chan(chan_in),
      .o_serial_out(serial_out), .o_rx_line(rx_line), .i_rx_char(rx_char),
      .o_rx_char_ready(char_ready), .i_host_pop(pop),
      .o_host_valid(host_valid), .o_host_data(host_data),
      .o_receive_ready_chan_n(rx_rdy_n), .o_transmit_ready_chan_n(tx_rdy_n),
      .o_receive_ready_all_n(rx_all_n), .o_transmit_ready_all_n(tx_all_n),
      .o_osc_clock_out(osc));
   remote_party far (.i_clk(clk), .i_rst_n(rst_n), .i_line_send(line_send),
      .i_line_bits(line_bits), .i_push(push), .i_push_ch(push_ch),
      .i_push_data(push_data), .i_char_ready(char_ready), .o_char(rx_char),
      .o_serial_in(serial_in));

   // ------------------------------------------------------------
   // compare, wait and closing tasks
   // ------------------------------------------------------------
   task chk_bit(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk_bit
   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t host byte got %h exp %h", $time, got, exp);
      end
   endtask : chk_byte
   task settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task summarize;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   // hang guard, far above the few hundred cycles the tests use
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         fails++;
         $display("BAD %0t run did not finish", $time);
         summarize();
      end
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task test_reset;
      // flops only take reset at the first edge, the level starts low
      settle(1);
      for (int c = 0; c < 4; c++) begin
         chk_bit(serial_out[c], 1'b1, "tx pin in reset");
         chk_bit(rx_line[c], 1'b1, "rx line in reset");
         chk_bit(host_valid[c], 1'b0, "host valid in reset");
      end
      chk_bit(rx_all_n & tx_all_n, 1'b1, "ready pins in reset");
      chk_bit(osc, OSC_RESET, "osc in reset");
      $display("test reset done");
   endtask : test_reset
   task test_osc;
      logic prev;
      @(negedge clk);
      prev = osc;
      @(negedge clk);
      chk_bit(osc, ~prev, "osc half rate");
      @(negedge clk);
      chk_bit(osc, prev, "osc half rate");
      $display("test osc done");
   endtask : test_osc
   task test_serial;
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            ctl[c] <= {1'b0, tbl[k][6:3], 1'b0};
            line_send[c] <= 1'b1;
            line_bits[c] <= tbl[k][2];
            settle(2);
            chk_bit(serial_out[c], tbl[k][1], "tx pin");
            chk_bit(rx_line[c], tbl[k][0], "rx line");
         end
         @(posedge clk);
         ctl[c] <= '0;
         line_send[c] <= 1'b0;
      end
      // reset in mid-character forces mark at once
      @(posedge clk);
      ctl[0] <= {1'b0, 4'h6, 1'b0};
      settle(2);
      chk_bit(serial_out[0], 1'b0, "tx pin sending");
      @(posedge clk);
      rst_n <= 1'b0;
      #1;
      chk_bit(serial_out[0], 1'b1, "tx pin on reset");
      settle(2);
      @(posedge clk);
      rst_n <= 1'b1;
      ctl[0] <= '0;
      $display("test serial done");
   endtask : test_serial
   task test_tx_ready;
      settle(2);
      chk_bit(tx_all_n, 1'b1, "tx ready all full");
      for (int c = 0; c < 4; c++) begin
         @(posedge clk);
         ctl[c].tx_space <= 1'b1;
         settle(2);
         chk_bit(tx_rdy_n[c], 1'b0, "tx ready chan");
         chk_bit(tx_all_n, 1'b0, "tx ready one free");
         @(posedge clk);
         ctl[c].tx_space <= 1'b0;
      end
      settle(2);
      chk_bit(tx_all_n, 1'b1, "tx ready all full again");
      $display("test tx ready done");
   endtask : test_tx_ready
   task test_rx_fill(input int ch, input int words);
      for (int i = 0; i < words; i++) begin
         @(posedge clk);
         push <= 1'b1;
         push_ch <= 2'(ch);
         push_data <= 8'(8'h10 + i);
      end
      @(posedge clk);
      push <= 1'b0;
      settle(20);
      if (words > 8) chk_bit(char_ready[ch], 1'b0, "full refuses");
      chk_bit(rx_rdy_n[ch], 1'b0, "rx ready chan");
      chk_bit(rx_all_n, 1'b0, "rx ready any");
      for (int i = 0; i < words; i++) begin
         @(posedge clk);
         pop[ch] <= 1'b1;
         @(posedge clk);
         pop[ch] <= 1'b0;
         @(negedge clk);
         chk_bit(host_valid[ch], 1'b1, "unload valid");
         chk_byte(host_data[ch], 8'(8'h10 + i));
         settle(4);
         if (i < words - 1) chk_bit(rx_all_n, 1'b0, "rx ready kept");
      end
      chk_bit(rx_all_n, 1'b1, "rx ready empty");
      @(posedge clk);
      pop[ch] <= 1'b1;
      @(posedge clk);
      pop[ch] <= 1'b0;
      @(negedge clk);
      chk_bit(host_valid[ch], 1'b0, "pop on empty");
      $display("test rx fill done");
   endtask : test_rx_fill

   initial begin
      test_reset();
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      test_osc();
      test_serial();
      test_tx_ready();
      test_rx_fill(2, 9);
      for (int c = 0; c < 4; c++) test_rx_fill(c, 1);
      summarize();
   end
endmodule : tb
